// File: dlh_defines.vh
// Constants for the data-link controller three block: register map,
// control field positions, line patterns and check-sequence values.
// Included by the design file; definitions only.
`ifndef DLH_DEFINES_VH
`define DLH_DEFINES_VH
// Register indices; byte address is four times the index
`define DLH_CTRL_IDX      12'h153
`define DLH_STAT_IDX      12'h154
`define DLH_CTRL_ADDR     14'h054c
`define DLH_STAT_ADDR     14'h0550
`define DLH_CTRL_RST      8'h00
// Control field positions
`define DLH_B_KIND        0
`define DLH_B_FCS_APPEND  1
`define DLH_B_FLAG_FILL   2
`define DLH_B_FORCE_ABORT 3
`define DLH_B_DUP_DROP    4
`define DLH_B_RX_CHK_INH  5
`define DLH_B_AUTO_AB_INH 6
// Line patterns, sent least significant bit first
`define DLH_FLAG          8'h7e
`define DLH_ABORT         8'hfe
`define DLH_ONES          8'hff
`define DLH_BOS_HEAD      8'hff
// Check sequence: reflected 16-bit polynomial, preset and good residue
`define DLH_CRC_POLY      16'h8408
`define DLH_CRC_INIT      16'hffff
`define DLH_CRC_GOOD      16'hf0b8
`define DLH_BUF_DEPTH     64
`define DLH_RESP_OKAY     2'b00
`define DLH_RESP_SLVERR   2'b10
`endif

// File: dlh_ctrl3.v
// Data-link HDLC controller three: control register, transmit framer
// and receive deframer with check sequence and duplicate discard.
// Assumes one clock; tx_bit_en/rx_bit_en mark the data-link bit slots.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dlh_defines.vh"
module dlh_ctrl3 (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  tx_msg_data,
  input  wire        tx_msg_valid,
  input  wire        tx_msg_last,
  output reg         tx_msg_ready,
  input  wire [5:0]  tx_bos_code,
  input  wire        tx_bit_en,
  output reg         tx_dl_bit,
  input  wire        rx_dl_bit,
  input  wire        rx_bit_en,
  output reg         rx_frame_done,
  output reg  [6:0]  rx_frame_len,
  output reg         rx_fcs_err,
  output reg         rx_dup_drop,
  output reg         rx_bos_valid,
  output reg  [5:0]  rx_bos_code
);
  localparam [4:0] S_IDLE = 5'b00001, S_DATA = 5'b00010, S_FCS = 5'b00100,
                   S_ABORT = 5'b01000, S_BOS = 5'b10000;

  // One bit of the reflected check-sequence shift
  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ `DLH_CRC_POLY) : (c >> 1);
    end
  endfunction

  reg  [7:0]  ctrl_q;
  reg         aw_have_q, w_have_q, bos_req_q;
  reg  [13:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [4:0]  tx_st_q;
  reg  [7:0]  tx_sh_q;
  reg  [2:0]  tx_cnt_q;
  reg  [2:0]  tx_ones_q;
  reg  [15:0] tx_crc_q;
  reg         tx_last_q, tx_fcs_hi_q, tx_bos_hi_q, tx_stuff_q;
  reg  [7:0]  rx_sr_q;
  reg  [7:0]  rx_byte_q;
  reg  [2:0]  rx_bcnt_q;
  reg  [2:0]  rx_ones_q;
  reg  [15:0] rx_crc_q;
  reg  [15:0] rx_crc_oct_q;
  reg  [6:0]  rx_len_q, held_len_q;
  reg         rx_in_q, rx_same_q, held_ok_q;
  reg  [15:0] bos_sr_q;
  reg  [5:0]  held_bos_q;
  reg         held_bos_ok_q;
  reg  [7:0]  rx_buf [0:`DLH_BUF_DEPTH-1];

  wire        wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire        wr_ctrl = wr_go & (aw_addr_q[13:2] == `DLH_CTRL_IDX) & w_strb_q[0];
  wire        is_mos  = ctrl_q[`DLH_B_KIND];
  wire        fill    = is_mos & ctrl_q[`DLH_B_FLAG_FILL];
  wire        do_fcs  = is_mos & ctrl_q[`DLH_B_FCS_APPEND];
  // Check value including the bit on the line now; low octet goes out first
  wire [15:0] tx_crc_nx = crc_step(tx_crc_q, tx_sh_q[0]);

  // Write channels are taken independently, so address and data may come in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 14'h0000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DLH_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == `DLH_CTRL_ADDR || aw_addr_q == `DLH_STAT_ADDR) ?
                        `DLH_RESP_OKAY : `DLH_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; a write with the select bit low is a one-shot send request
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= `DLH_CTRL_RST;
      bos_req_q <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= {1'b0, w_data_q[6:0]};
      if (wr_ctrl & ~w_data_q[`DLH_B_KIND])
        bos_req_q <= 1'b1;
      else if (tx_bit_en & tx_st_q[4] & tx_cnt_q == 3'd7 & tx_bos_hi_q)
        bos_req_q <= 1'b0;
    end
  end

  // Reads answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DLH_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DLH_RESP_OKAY;
        if (s_axi_araddr == `DLH_CTRL_ADDR)
          s_axi_rdata <= {24'h000000, ctrl_q};
        else if (s_axi_araddr == `DLH_STAT_ADDR)
          s_axi_rdata <= {16'h0000, held_ok_q, held_len_q, 2'b00, bos_req_q, tx_st_q};
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DLH_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Transmit framer: one line bit per tx_bit_en, least significant bit first
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q      <= S_IDLE;
      tx_sh_q      <= `DLH_FLAG;
      tx_cnt_q     <= 3'd0;
      tx_ones_q    <= 3'd0;
      tx_crc_q     <= `DLH_CRC_INIT;
      tx_last_q    <= 1'b0;
      tx_fcs_hi_q  <= 1'b0;
      tx_bos_hi_q  <= 1'b0;
      tx_stuff_q   <= 1'b0;
      tx_msg_ready <= 1'b0;
      tx_dl_bit    <= 1'b1;
    end else begin
      tx_msg_ready <= 1'b0;
      if (tx_bit_en) begin
        if (tx_stuff_q) begin
          tx_dl_bit  <= 1'b0;
          tx_stuff_q <= 1'b0;
          tx_ones_q  <= 3'd0;
        end else if (ctrl_q[`DLH_B_FORCE_ABORT] & ~tx_st_q[4]) begin
          tx_dl_bit <= 1'b1;
          tx_st_q   <= S_IDLE;
          tx_cnt_q  <= 3'd0;
          tx_sh_q   <= `DLH_FLAG;
        end else if ((tx_st_q[1] | tx_st_q[2]) & bos_req_q) begin
          tx_st_q   <= ctrl_q[`DLH_B_AUTO_AB_INH] ? S_BOS : S_ABORT;
          tx_sh_q   <= ctrl_q[`DLH_B_AUTO_AB_INH] ? `DLH_BOS_HEAD : `DLH_ABORT;
          tx_cnt_q  <= 3'd0;
          tx_bos_hi_q <= 1'b0;
          tx_dl_bit <= ctrl_q[`DLH_B_AUTO_AB_INH];
          tx_ones_q <= 3'd0;
        end else begin
          tx_dl_bit <= tx_sh_q[0];
          tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
          tx_cnt_q  <= tx_cnt_q + 3'd1;
          if (tx_st_q[1] | tx_st_q[2]) begin
            tx_ones_q  <= tx_sh_q[0] ? tx_ones_q + 3'd1 : 3'd0;
            tx_stuff_q <= tx_sh_q[0] & (tx_ones_q == 3'd4);
          end
          if (tx_st_q[1])
            tx_crc_q <= crc_step(tx_crc_q, tx_sh_q[0]);
          if (tx_cnt_q == 3'd7) begin
            case (tx_st_q)
              S_IDLE: begin
                // mode picks what starts; flags when idle; fill holds frames
                if (bos_req_q & ~is_mos) begin
                  tx_st_q     <= S_BOS;
                  tx_sh_q     <= `DLH_BOS_HEAD;
                  tx_bos_hi_q <= 1'b0;
                end else if (is_mos & ~fill & tx_msg_valid) begin
                  tx_st_q      <= S_DATA;
                  tx_sh_q      <= tx_msg_data;
                  tx_last_q    <= tx_msg_last;
                  tx_msg_ready <= 1'b1;
                  tx_crc_q     <= `DLH_CRC_INIT;
                  tx_ones_q    <= 3'd0;
                end else
                  tx_sh_q <= `DLH_FLAG;
              end
              S_DATA: begin
                if (!tx_last_q & tx_msg_valid) begin
                  tx_sh_q      <= tx_msg_data;
                  tx_last_q    <= tx_msg_last;
                  tx_msg_ready <= 1'b1;
                end else if (!tx_last_q) begin
                  // Source ran dry mid-frame: the frame is aborted
                  tx_st_q <= S_ABORT;
                  tx_sh_q <= `DLH_ABORT;
                end else if (do_fcs) begin
                  tx_st_q     <= S_FCS;
                  tx_sh_q     <= ~tx_crc_nx[7:0];
                  tx_fcs_hi_q <= 1'b1;
                end else begin
                  tx_st_q <= S_IDLE;
                  tx_sh_q <= `DLH_FLAG;
                end
              end
              S_FCS: begin
                if (tx_fcs_hi_q) begin
                  tx_sh_q     <= ~tx_crc_q[15:8];
                  tx_fcs_hi_q <= 1'b0;
                end else begin
                  tx_st_q <= S_IDLE;
                  tx_sh_q <= `DLH_FLAG;
                end
              end
              S_ABORT: begin
                tx_st_q     <= bos_req_q ? S_BOS : S_IDLE;
                tx_sh_q     <= bos_req_q ? `DLH_BOS_HEAD : `DLH_FLAG;
                tx_bos_hi_q <= 1'b0;
              end
              S_BOS: begin
                if (!tx_bos_hi_q) begin
                  tx_sh_q     <= {1'b0, tx_bos_code, 1'b0};
                  tx_bos_hi_q <= 1'b1;
                end else begin
                  tx_st_q <= S_IDLE;
                  tx_sh_q <= `DLH_FLAG;
                end
              end
              default: begin
                tx_st_q <= S_IDLE;
                tx_sh_q <= `DLH_FLAG;
              end
            endcase
          end
        end
      end
    end
  end

  // Receive deframer: flags delimit, five ones then zero is a stuffed bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_sr_q       <= 8'h00;
      rx_byte_q     <= 8'h00;
      rx_bcnt_q     <= 3'd0;
      rx_ones_q     <= 3'd0;
      rx_crc_q      <= `DLH_CRC_INIT;
      rx_crc_oct_q  <= `DLH_CRC_INIT;
      rx_len_q      <= 7'd0;
      rx_in_q       <= 1'b0;
      rx_same_q     <= 1'b0;
      held_len_q    <= 7'd0;
      held_ok_q     <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_frame_len  <= 7'd0;
      rx_fcs_err    <= 1'b0;
      rx_dup_drop   <= 1'b0;
    end else begin
      rx_frame_done <= 1'b0;
      rx_fcs_err    <= 1'b0;
      rx_dup_drop   <= 1'b0;
      if (rx_bit_en) begin
        rx_sr_q   <= {rx_dl_bit, rx_sr_q[7:1]};
        rx_ones_q <= rx_dl_bit ? ((rx_ones_q == 3'd7) ? 3'd7 : rx_ones_q + 3'd1) : 3'd0;
        if (rx_dl_bit & rx_ones_q == 3'd6) begin
          // Seven ones: abort, frame thrown away
          rx_in_q <= 1'b0;
        end else if (!rx_dl_bit & rx_ones_q == 3'd6) begin
          // Flag closes any open frame and opens the next
          if (rx_in_q & rx_len_q > 7'd2 & rx_bcnt_q == 3'd7) begin
            // check only when enabled
            // Octet-boundary value: the closing flag's bits must not enter the check
            if (!ctrl_q[`DLH_B_RX_CHK_INH] & rx_crc_oct_q != `DLH_CRC_GOOD) begin
              rx_fcs_err <= 1'b1;
              held_ok_q  <= 1'b0;
            end else if (ctrl_q[`DLH_B_DUP_DROP] & held_ok_q & rx_same_q & rx_len_q == held_len_q) begin
              rx_dup_drop <= 1'b1;
            end else begin
              rx_frame_done <= 1'b1;
              rx_frame_len  <= rx_len_q;
              held_len_q    <= rx_len_q;
              held_ok_q     <= 1'b1;
            end
          end
          rx_in_q   <= 1'b1;
          rx_bcnt_q <= 3'd0;
          rx_len_q  <= 7'd0;
          rx_crc_q  <= `DLH_CRC_INIT;
          rx_crc_oct_q <= `DLH_CRC_INIT;
          rx_same_q <= 1'b1;
        end else if (rx_in_q & !(!rx_dl_bit & rx_ones_q == 3'd5)) begin
          rx_byte_q <= {rx_dl_bit, rx_byte_q[7:1]};
          rx_bcnt_q <= rx_bcnt_q + 3'd1;
          rx_crc_q  <= crc_step(rx_crc_q, rx_dl_bit);
          if (rx_bcnt_q == 3'd7) begin
            rx_crc_oct_q <= crc_step(rx_crc_q, rx_dl_bit);
            // Compare against the held byte before it is overwritten
            if (rx_len_q < `DLH_BUF_DEPTH) begin
              if (rx_buf[rx_len_q[5:0]] != {rx_dl_bit, rx_byte_q[7:1]})
                rx_same_q <= 1'b0;
            end
            if (rx_len_q != 7'h7f)
              rx_len_q <= rx_len_q + 7'd1;
          end
        end
      end
    end
  end

  // Receive buffer write, no reset needed for storage
  always @(posedge aclk) begin
    if (rx_bit_en & rx_in_q & rx_bcnt_q == 3'd7 & rx_len_q < `DLH_BUF_DEPTH &
        !(rx_ones_q >= 3'd5))
      rx_buf[rx_len_q[5:0]] <= {rx_dl_bit, rx_byte_q[7:1]};
  end

  // Bit-oriented receive: eight ones, then 0 code 0
  always @(posedge aclk) begin
    if (!aresetn) begin
      bos_sr_q      <= 16'h0000;
      held_bos_q    <= 6'd0;
      held_bos_ok_q <= 1'b0;
      rx_bos_valid  <= 1'b0;
      rx_bos_code   <= 6'd0;
    end else begin
      rx_bos_valid <= 1'b0;
      if (rx_bit_en) begin
        bos_sr_q <= {rx_dl_bit, bos_sr_q[15:1]};
        if (bos_sr_q[8:1] == `DLH_BOS_HEAD & !bos_sr_q[9] & !rx_dl_bit) begin
          if (!(ctrl_q[`DLH_B_DUP_DROP] & held_bos_ok_q & held_bos_q == bos_sr_q[15:10])) begin
            rx_bos_valid  <= 1'b1;
            rx_bos_code   <= bos_sr_q[15:10];
            held_bos_q    <= bos_sr_q[15:10];
            held_bos_ok_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// File: dlh_ctrl3_monitor.sv
// Checker for the data-link controller three: bus answers, receive pulses
// and transmit behaviour once a control value has stood for a while.
// Assumes wstrb held at all ones and a bit slot every other cycle.
`timescale 1ns/1ps
`include "dlh_defines.vh"
module dlh_ctrl3_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire [13:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        tx_msg_ready,
  input wire        tx_dl_bit,
  input wire        rx_fcs_err,
  input wire        rx_dup_drop
);
  reg [13:0] wa_q;
  reg [7:0]  wd_q;
  reg [7:0]  ctrl_q;
  reg [7:0]  age_q;
  wire       settled = age_q > 8'hc8;
  // Shadow control value; age lets in-flight octets drain before checks
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 8'h00;
      age_q  <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (s_axi_bvalid && s_axi_bready && wa_q == `DLH_CTRL_ADDR && s_axi_bresp == 2'h0) begin
        ctrl_q <= {1'b0, wd_q[6:0]};
        age_q  <= 8'h00;
      end else if (age_q != 8'hff) age_q <= age_q + 8'h01;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  chk_b_bound: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  chk_b_hold: assert property (s_b_wait |=> s_axi_bvalid) else $error("write answer dropped");
  chk_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer unstable");
  chk_rdy_pulse: assert property (tx_msg_ready |=> !tx_msg_ready) else $error("byte taken twice");
  chk_fcs_inh: assert property (rx_fcs_err |-> !ctrl_q[5]) else $error("check error while inhibited");
  chk_dup_en: assert property (rx_dup_drop |-> ctrl_q[4]) else $error("repeat dropped while off");
  chk_abort_ones: assert property (settled && ctrl_q[3] |-> tx_dl_bit) else $error("abort not all ones");
  chk_fill_idle: assert property (settled && ctrl_q[0] && ctrl_q[2] |-> !tx_msg_ready) else $error("frame under fill");
  chk_bit_nomsg: assert property (settled && !ctrl_q[0] |-> !tx_msg_ready) else $error("frame in bit mode");
endmodule
bind dlh_ctrl3 dlh_ctrl3_monitor mon_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_msg_ready, .tx_dl_bit, .rx_fcs_err,
  .rx_dup_drop);

// File: dlh_remote.sv
// Remote terminal model: makes the bit slots, sends frames on the receive
// line and deframes the transmit line. Assumes the aclk domain only.
`timescale 1ns/1ps
module dlh_remote (
  input  wire aclk,
  output reg  tx_bit_en = 1'b0,
  input  wire tx_dl_bit,
  output reg  rx_bit_en = 1'b0,
  output reg  rx_dl_bit = 1'b1
);
  bit       q[$];
  reg [7:0] sh = 8'h00;
  reg       smp_q = 1'b0;
  integer   o = 0, nb = 0, run = 0, run_max = 0, fr_len = 0, fr_cnt = 0, flags = 0;
  task put(input [7:0] b, input stf);
    integer i;
    for (i = 0; i < 8; i++) begin
      q.push_back(b[i]);
      o = (b[i] && stf) ? o + 1 : 0;
      if (o == 5) begin
        q.push_back(1'b0);
        o = 0;
      end
    end
  endtask
  // Bit-oriented message: eight ones, then 0, code, 0, unstuffed
  task send_bos(input [5:0] cd);
    put(8'hff, 1'b0);
    put({1'b0, cd, 1'b0}, 1'b0);
  endtask
  task send(input integer n, input [7:0] s, input bad);
    reg [15:0] c;
    reg [7:0]  d;
    integer    i, k;
    c = 16'hffff;
    put(8'h7e, 1'b0);
    for (i = 0; i < n; i++) begin
      d = s + 8'(i);
      put(d, 1'b1);
      for (k = 0; k < 8; k++) c = (c[0] ^ d[k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    c = ~c ^ {15'h0000, bad};
    put(c[7:0], 1'b1);
    put(c[15:8], 1'b1);
    put(8'h7e, 1'b0);
  endtask
  // Slots every other cycle; idle receive line carries flags, not stale bits
  always @(posedge aclk) begin
    tx_bit_en <= ~tx_bit_en;
    rx_bit_en <= ~rx_bit_en;
    smp_q <= tx_bit_en;
    if (!rx_bit_en) begin
      if (q.size() == 0) put(8'h7e, 1'b0);
      rx_dl_bit <= q.pop_front();
    end
    if (smp_q) begin
      sh = {tx_dl_bit, sh[7:1]};
      if (sh == 8'h7e) begin
        flags = flags + 1;
        if (nb >= 23 && (nb - 7) % 8 == 0) begin
          fr_cnt = fr_cnt + 1;
          fr_len = (nb - 7) / 8;
        end
        nb = 0;
      end else if (!(run == 5 && !tx_dl_bit)) nb = nb + 1;
      run = tx_dl_bit ? run + 1 : 0;
      if (run >= 7) nb = 0;
      if (run > run_max) run_max = run;
    end
  end
endmodule

// File: dlh_ctrl3_tb.sv
// Self-checking bench for the data-link controller three.
// Assumes the remote model owns the bit slots and the serial lines.
`timescale 1ns/1ps
`include "dlh_defines.vh"
module dlh_ctrl3_tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, tx_msg_valid = 0, tx_msg_last = 0;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [7:0]  tx_msg_data = 0, v, s;
  logic [5:0]  tx_bos_code = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  r, last_kind = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_msg_ready, tx_dl_bit;
  wire rx_dl_bit, tx_bit_en, rx_bit_en, rx_frame_done, rx_fcs_err, rx_dup_drop, rx_bos_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0] rx_frame_len;
  wire [5:0] rx_bos_code;
  integer n_errors = 0, comparisons = 0, n_ev = 0, n_rdy = 0, last_len = 0, k, n, b, f, n_bos = 0;
  logic [5:0]  last_bos = 0;
  logic [7:0] rc[6] = '{8'h01, 8'h01, 8'h21, 8'h01, 8'h11, 8'h01};
  logic [7:0] sw[4] = '{8'h00, 8'h40, 8'h04, 8'h06};
  dlh_ctrl3 dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_msg_data, .tx_msg_valid,
    .tx_msg_last, .tx_msg_ready, .tx_bos_code, .tx_bit_en, .tx_dl_bit, .rx_dl_bit, .rx_bit_en, .rx_frame_done,
    .rx_frame_len, .rx_fcs_err, .rx_dup_drop, .rx_bos_valid, .rx_bos_code);
  dlh_remote rem_u (.aclk, .tx_bit_en, .tx_dl_bit, .rx_bit_en, .rx_dl_bit);
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  // Receive outcome and byte-taken tallies, read at the falling edge
  always @(posedge aclk) begin
    if (tx_msg_ready) n_rdy = n_rdy + 1;
    if (rx_bos_valid) begin
      n_bos = n_bos + 1;
      last_bos = rx_bos_code;
    end
    if (rx_frame_done || rx_fcs_err || rx_dup_drop) begin
      n_ev = n_ev + 1;
      last_kind = rx_dup_drop ? 2'h2 : rx_fcs_err ? 2'h1 : 2'h0;
      last_len = rx_frame_len;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function [1:0] rx_exp(input [7:0] c, input bad, input same);
    rx_exp = (c[4] && same) ? 2'h2 : (bad && !c[5]) ? 2'h1 : 2'h0;
  endfunction
  function integer tx_len(input [7:0] c, input integer n);
    tx_len = n + ((c[0] && c[1]) ? 2 : 0);
  endfunction
  task wr(input [13:0] a, input [31:0] dv, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    check(s_axi_bresp, er);
  endtask
  task rd(input [13:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Feed one frame, holding each byte until it is taken
  task tx_frame(input integer n, input [7:0] c);
    integer i, f0;
    f0 = rem_u.fr_cnt;
    for (i = 0; i < n; i++) begin
      tx_msg_data <= 8'($urandom);
      tx_msg_last <= (i == n - 1);
      tx_msg_valid <= 1;
      do @(posedge aclk); while (!tx_msg_ready);
    end
    tx_msg_valid <= 0;
    do @(negedge aclk); while (rem_u.fr_cnt == f0);
    check(rem_u.fr_len, tx_len(c, n));
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors = n_errors + 1;
    finish_test;
  end
  initial begin
    void'($urandom(14));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (100) @(negedge aclk);
    check(rem_u.flags > 3, 1);
    rd(`DLH_CTRL_ADDR);
    check(d, 32'h0);
    v = 8'($urandom);
    wr(`DLH_CTRL_ADDR, {24'h0, v | 8'h80}, 2'h0);
    rd(`DLH_CTRL_ADDR);
    check(d, {24'h0, v & 8'h7f});
    rd(14'h0100);
    check(r, 2'h2);
    wr(14'h0100, 32'h0, 2'h2);
    for (k = 1; k < 4; k += 2) begin
      wr(`DLH_CTRL_ADDR, k, 2'h0);
      tx_frame(3 + $urandom % 8, 8'(k));
    end
    wr(`DLH_CTRL_ADDR, 32'h05, 2'h0);
    b = n_rdy;
    f = rem_u.flags;
    fork
      tx_frame(3 + $urandom % 8, 8'h01);
      begin
        repeat (300) @(negedge aclk);
        check(n_rdy, b);
        check(rem_u.flags > f + 10, 1);
        wr(`DLH_CTRL_ADDR, 32'h01, 2'h0);
      end
    join
    for (k = 0; k < 4; k++) begin
      wr(`DLH_CTRL_ADDR, 32'h01, 2'h0);
      // Zero data keeps ones runs before the cut short of the abort threshold
      tx_msg_data <= 8'h00;
      tx_msg_valid <= 1;
      tx_msg_last <= 0;
      tx_bos_code <= 6'($urandom);
      repeat (200) @(posedge aclk);
      wr(`DLH_CTRL_ADDR, {24'h0, sw[k]}, 2'h0);
      @(negedge aclk);
      rem_u.run_max = 0;
      repeat (300) @(negedge aclk);
      check(rem_u.run_max >= 14, !sw[k][6]);
      check(rem_u.run_max >= 8, 1);
    end
    tx_msg_valid <= 0;
    wr(`DLH_CTRL_ADDR, 32'h09, 2'h0);
    repeat (300) @(negedge aclk);
    check(rem_u.run >= 100, 1);
    for (k = 0; k < 6; k++) begin
      if (k < 4) begin
        n = 3 + $urandom % 8;
        s = 8'($urandom);
      end
      wr(`DLH_CTRL_ADDR, {24'h0, rc[k]}, 2'h0);
      b = n_ev;
      rem_u.send(n, s, k == 1 || k == 2);
      do @(negedge aclk); while (n_ev == b);
      check(last_kind, rx_exp(rc[k], k == 1 || k == 2, k > 3));
      if (last_kind == 2'h0) check(last_len, n + 2);
    end
    // Bit-oriented receive, then the same code again with repeat drop on
    s = 8'($urandom);
    wr(`DLH_CTRL_ADDR, 32'h01, 2'h0);
    b = n_bos;
    rem_u.send_bos(s[5:0]);
    do @(negedge aclk); while (n_bos == b);
    check(last_bos, s[5:0]);
    wr(`DLH_CTRL_ADDR, 32'h11, 2'h0);
    b = n_bos;
    rem_u.send_bos(s[5:0]);
    repeat (200) @(negedge aclk);
    check(n_bos, b);
    finish_test;
  end
endmodule
